// >>> core/bldc_defines.svh
`ifndef BLDC_DEFINES_SVH
`define BLDC_DEFINES_SVH

// Reference clock enable divider from the 250 MHz system clock.
`define REF_DIV 27
`define CARRIER_DIV 512
`define DEAD_TICKS 18
`define HALL_SLOW_TICKS 1536000
// Frequencies in hundredths of a hertz; pulse suppression limit scales from the 1 Hz limit.
`define SPEED_LIMIT_CHZ 100
`define PULSE_LIMIT_CHZ 68
`define PULSE_SLOW_TICKS ((`HALL_SLOW_TICKS * `SPEED_LIMIT_CHZ) / `PULSE_LIMIT_CHZ)
`define STEPS_PER_SECTOR 64
`define DUTY_MAX_SINE 493
`define DUTY_MAX_SQUARE 435
`define DUTY_MIN 2
// Lock oscillator nominal rate and the two protection periods in seconds.
`define LOCK_OSC_HZ 100
`define LOCK_ON_S 5
`define LOCK_OFF_S 30
`define PULSE_START_EDGES 9
`define PULSE_ACC_MOD 15

`endif

// >>> core/bldc_pkg.sv
package bldc_pkg;

	// Pins sampled together through the synchroniser.
	typedef struct packed {
		logic [2:0] hall;
		logic [4:0] advance;
		logic [2:0] pulse_sel;
		logic [7:0] duty;
		logic lock_cap;
	} pins_type;

	// Wanted state of one half bridge.
	typedef struct packed {
		logic en;
		logic hi;
	} phase_cmd_type;

	typedef enum logic [1:0] {
		SIDE_OFF = 2'b00,
		SIDE_HIGH = 2'b01,
		SIDE_LOW = 2'b10
	} side_type;

	typedef enum logic {
		LOCK_RUN = 1'b0,
		LOCK_OFF = 1'b1
	} lock_state_type;

	typedef enum logic [2:0] {
		PULSE_ONE = 3'b000,
		PULSE_THREE = 3'b001,
		PULSE_R24 = 3'b010,
		PULSE_R20 = 3'b011,
		PULSE_R08 = 3'b100
	} pulse_mode_type;

endpackage

// >>> core/gate_dead_time.sv
`timescale 1ns/1ps
`include "bldc_defines.svh"

module gate_dead_time import bldc_pkg::*; (
	// Clock, reset and reference tick.
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ref_tick,
	// Wanted bridge state.
	input wire phase_cmd_type cmd,
	// Gate drive.
	output logic high_gate,
	output logic low_gate
);

	side_type side_q, side_d, want;
	logic [4:0] dead_q, dead_d;

	////////////////////////////////////////////////////////////////////////////////
	// Any change of side passes through off for the dead time, so both
	// gates can never be on at once even if the command flips every cycle.
	always_comb begin
		want = cmd.en ? (cmd.hi ? SIDE_HIGH : SIDE_LOW) : SIDE_OFF;
		side_d = side_q;
		dead_d = dead_q;
		if (want != side_q) begin
			if (side_q != SIDE_OFF) begin
				side_d = SIDE_OFF;
				dead_d = 5'h00;
			end else if (dead_q == 5'(`DEAD_TICKS)) begin
				side_d = want;
			end
		end
		if (side_d == SIDE_OFF && side_q == SIDE_OFF && ref_tick && dead_q != 5'(`DEAD_TICKS)) begin
			dead_d = dead_q + 5'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			side_q <= SIDE_OFF;
			dead_q <= 5'h00;
		end else begin
			side_q <= side_d;
			dead_q <= dead_d;
		end
	end

	// Gates straight from the side register.
	assign high_gate = (side_q == SIDE_HIGH);
	assign low_gate = (side_q == SIDE_LOW);

endmodule // gate_dead_time

// >>> core/bldc_sine_pwm_commutator.sv
`timescale 1ns/1ps
`include "bldc_defines.svh"

module bldc_sine_pwm_commutator import bldc_pkg::*; #(
	parameter int unsigned REF_DIV = `REF_DIV,
	parameter int unsigned SLOW_TICKS = `HALL_SLOW_TICKS,
	parameter int unsigned PULSE_SLOW_TICKS = `PULSE_SLOW_TICKS,
	parameter int unsigned LOCK_ON_CYCLES = `LOCK_ON_S * `LOCK_OSC_HZ,
	parameter int unsigned LOCK_OFF_CYCLES = `LOCK_OFF_S * `LOCK_OSC_HZ
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Hall position pins.
	input wire logic u_hall_plus,
	input wire logic v_hall_plus,
	input wire logic w_hall_plus,
	// Strap and command pins.
	input wire logic [4:0] phase_advance_command,
	input wire logic [2:0] pulse_count_select,
	input wire logic [7:0] duty_command,
	input wire logic lock_timer_cap,
	// Gate drive to the power stage.
	output logic u_high_gate,
	output logic u_low_gate,
	output logic v_high_gate,
	output logic v_low_gate,
	output logic w_high_gate,
	output logic w_low_gate,
	// Rotation pulse and drive status.
	output logic rotation_pulse_out,
	output logic sine_mode
);

	// Quarter-wave sine magnitude, sixteen steps over 90 degrees.
	function automatic logic [7:0] sine_lut(input logic [3:0] i);
		logic [7:0] t [16];
		t = '{8'h0C, 8'h25, 8'h3E, 8'h56, 8'h6D, 8'h83, 8'h98, 8'hAB,
			8'hBD, 8'hCD, 8'hDB, 8'hE7, 8'hF0, 8'hF7, 8'hFC, 8'hFF};
		return t[i];
	endfunction

	// Hall code {w,v,u} to sector 0..5; 7 marks an illegal code.
	function automatic logic [2:0] hall_sector(input logic [2:0] h);
		case (h)
			3'h1: return 3'h0;
			3'h3: return 3'h1;
			3'h2: return 3'h2;
			3'h6: return 3'h3;
			3'h4: return 3'h4;
			3'h5: return 3'h5;
			default: return 3'h7;
		endcase
	endfunction

	// Zero stays off; any other duty is held between the minimum and the cap.
	function automatic logic [8:0] clamp_duty(input logic [8:0] x, input logic [8:0] cap);
		if (x == 9'h000) return 9'h000;
		if (x < 9'(`DUTY_MIN)) return 9'(`DUTY_MIN);
		if (x > cap) return cap;
		return x;
	endfunction

	// Sine compare value around mid carrier for an angle in 384 steps per cycle.
	function automatic logic [8:0] sine_cmp(input logic [8:0] a, input logic [7:0] duty);
		logic [8:0] b;
		logic [8:0] q;
		logic [15:0] m;
		b = (a >= 9'd192) ? a - 9'd192 : a;
		q = (b < 9'd96) ? b : 9'd191 - b;
		m = 16'(sine_lut(4'(q / 9'd6))) * 16'(duty);
		if (a >= 9'd192) return 9'h100 - 9'(m[15:8]);
		return 9'h100 + 9'(m[15:8]);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser; only the second stage is read by logic.
	pins_type pin0_q, pin1_q, raw;
	assign raw = '{hall: {w_hall_plus, v_hall_plus, u_hall_plus},
		advance: phase_advance_command, pulse_sel: pulse_count_select,
		duty: duty_command, lock_cap: lock_timer_cap};

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin0_q <= '0;
			pin1_q <= '0;
		end else begin
			pin0_q <= raw;
			pin1_q <= pin0_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reference clock enable and carrier counter.
	logic [7:0] div_q, div_d;
	logic [8:0] car_q, car_d;
	logic ref_tick, car_wrap;
	assign ref_tick = (div_q == 8'(REF_DIV - 1));
	assign car_wrap = ref_tick && (car_q == 9'(`CARRIER_DIV - 1));

	always_comb begin
		div_d = ref_tick ? 8'h00 : div_q + 8'h01;
		car_d = ref_tick ? car_q + 9'h001 : car_q;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_q <= 8'h00;
			car_q <= 9'h000;
		end else begin
			div_q <= div_d;
			car_q <= car_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Speed, direction and position between Hall edges.
	logic [2:0] hall_q, sec_q, sec_d, sec_now, sec_next;
	logic [21:0] per_q, per_d, last_q, last_d;
	logic [15:0] sub_q, sub_d;
	logic [5:0] frac_q, frac_d;
	logic fast_q, fast_d, pfast_q, pfast_d, rev_q, rev_d, hall_edge;
	assign sec_now = hall_sector(pin1_q.hall);
	assign sec_next = (sec_q == 3'h5) ? 3'h0 : sec_q + 3'h1;
	assign hall_edge = (pin1_q.hall != hall_q);

	always_comb begin
		sec_d = sec_q;
		per_d = per_q;
		last_d = last_q;
		sub_d = sub_q;
		frac_d = frac_q;
		fast_d = fast_q;
		pfast_d = pfast_q;
		rev_d = rev_q;
		if (ref_tick) begin
			if (per_q != 22'(PULSE_SLOW_TICKS)) per_d = per_q + 22'h1;
			if (per_q >= 22'(SLOW_TICKS)) fast_d = 1'b0;
			if (per_q >= 22'(PULSE_SLOW_TICKS)) pfast_d = 1'b0;
			// Interpolate 64 steps per sector from the previous sector time.
			if (sub_q >= 16'(last_q >> 6)) begin
				sub_d = 16'h0000;
				if (frac_q != 6'(`STEPS_PER_SECTOR - 1)) frac_d = frac_q + 6'h01;
			end else begin
				sub_d = sub_q + 16'h0001;
			end
		end
		// An edge wins over a tick in the same cycle.
		if (hall_edge) begin
			last_d = per_q;
			fast_d = (per_q < 22'(SLOW_TICKS));
			pfast_d = (per_q < 22'(PULSE_SLOW_TICKS));
			rev_d = (sec_now != sec_next);
			per_d = 22'h0;
			sub_d = 16'h0000;
			frac_d = 6'h00;
			sec_d = sec_now;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hall_q <= 3'h0;
			sec_q <= 3'h7;
			per_q <= 22'h0;
			last_q <= 22'h0;
			sub_q <= 16'h0000;
			frac_q <= 6'h00;
			fast_q <= 1'b0;
			pfast_q <= 1'b0;
			rev_q <= 1'b0;
		end else begin
			hall_q <= pin1_q.hall;
			sec_q <= sec_d;
			per_q <= per_d;
			last_q <= last_d;
			sub_q <= sub_d;
			frac_q <= frac_d;
			fast_q <= fast_d;
			pfast_q <= pfast_d;
			rev_q <= rev_d;
		end
	end

	// Sine only when fast and turning forward; reverse falls back to square.
	assign sine_mode = fast_q && !rev_q;

	////////////////////////////////////////////////////////////////////////////////
	// Motor lock protection timed on the lock oscillator's rising edges.
	lock_state_type lock_q, lock_d;
	logic [11:0] lcnt_q, lcnt_d;
	logic cap_q, cap_rise;
	assign cap_rise = pin1_q.lock_cap && !cap_q;

	always_comb begin
		lock_d = lock_q;
		lcnt_d = lcnt_q;
		case (lock_q)
			LOCK_RUN: begin
				if (hall_edge) begin
					lcnt_d = 12'h000;
				end else if (cap_rise) begin
					lcnt_d = lcnt_q + 12'h001;
					if (lcnt_q == 12'(LOCK_ON_CYCLES - 1)) begin
						lock_d = LOCK_OFF;
						lcnt_d = 12'h000;
					end
				end
			end
			LOCK_OFF: begin
				if (cap_rise) begin
					lcnt_d = lcnt_q + 12'h001;
					if (lcnt_q == 12'(LOCK_OFF_CYCLES - 1)) begin
						lock_d = LOCK_RUN;
						lcnt_d = 12'h000;
					end
				end
			end
			default: begin
				lock_d = LOCK_RUN;
				lcnt_d = 12'h000;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lock_q <= LOCK_RUN;
			lcnt_q <= 12'h000;
			cap_q <= 1'b0;
		end else begin
			lock_q <= lock_d;
			lcnt_q <= lcnt_d;
			cap_q <= pin1_q.lock_cap;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare values, reloaded only at the carrier wrap to avoid runt pulses.
	logic [9:0] ang_raw;
	logic [8:0] ang, ang_v, ang_w;
	logic [8:0] cmp_q [3];
	logic [8:0] cmp_d [3];
	assign ang_raw = 10'(sec_q) * 10'(`STEPS_PER_SECTOR) + 10'(frac_q)
		+ (rev_q ? 10'h000 : 10'({pin1_q.advance, 1'b0}));
	assign ang = (ang_raw >= 10'd384) ? 9'(ang_raw - 10'd384) : 9'(ang_raw);
	assign ang_v = (ang >= 9'd128) ? ang - 9'd128 : ang + 9'd256;
	assign ang_w = (ang >= 9'd256) ? ang - 9'd256 : ang + 9'd128;

	always_comb begin
		cmp_d = cmp_q;
		if (car_wrap) begin
			if (sine_mode) begin
				cmp_d[0] = clamp_duty(sine_cmp(ang, pin1_q.duty), 9'(`DUTY_MAX_SINE));
				cmp_d[1] = clamp_duty(sine_cmp(ang_v, pin1_q.duty), 9'(`DUTY_MAX_SINE));
				cmp_d[2] = clamp_duty(sine_cmp(ang_w, pin1_q.duty), 9'(`DUTY_MAX_SINE));
			end else begin
				cmp_d[0] = clamp_duty({pin1_q.duty, 1'b0}, 9'(`DUTY_MAX_SQUARE));
				cmp_d[1] = cmp_d[0];
				cmp_d[2] = cmp_d[0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cmp_q <= '{9'h000, 9'h000, 9'h000};
		end else begin
			cmp_q <= cmp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Phase commands: all three modulate in sine; one PWM, one low, one off in square.
	phase_cmd_type cmd [3];
	logic [1:0] pwm_ph, low_ph;
	logic out_ok;
	assign out_ok = (lock_q == LOCK_RUN) && (sec_q != 3'h7) && (pin1_q.duty != 8'h00);

	always_comb begin
		case (sec_q)
			3'h0: begin pwm_ph = 2'd0; low_ph = 2'd1; end
			3'h1: begin pwm_ph = 2'd0; low_ph = 2'd2; end
			3'h2: begin pwm_ph = 2'd1; low_ph = 2'd2; end
			3'h3: begin pwm_ph = 2'd1; low_ph = 2'd0; end
			3'h4: begin pwm_ph = 2'd2; low_ph = 2'd0; end
			default: begin pwm_ph = 2'd2; low_ph = 2'd1; end
		endcase
		for (int i = 0; i < 3; i++) begin
			cmd[i].hi = (car_q < cmp_q[i]);
			if (sine_mode) begin
				cmd[i].en = out_ok;
			end else begin
				cmd[i].en = out_ok && (2'(i) == pwm_ph || 2'(i) == low_ph);
				if (2'(i) == low_ph) cmd[i].hi = 1'b0;
			end
		end
	end

	gate_dead_time u_bridge (.sys_clk(sys_clk), .rst(rst), .ref_tick(ref_tick),
		.cmd(cmd[0]), .high_gate(u_high_gate), .low_gate(u_low_gate));
	gate_dead_time v_bridge (.sys_clk(sys_clk), .rst(rst), .ref_tick(ref_tick),
		.cmd(cmd[1]), .high_gate(v_high_gate), .low_gate(v_low_gate));
	gate_dead_time w_bridge (.sys_clk(sys_clk), .rst(rst), .ref_tick(ref_tick),
		.cmd(cmd[2]), .high_gate(w_high_gate), .low_gate(w_low_gate));

	////////////////////////////////////////////////////////////////////////////////
	// Rotation pulse. Fractional ratios use an accumulator per Hall edge, so
	// they are not tied to any particular Hall phase.
	logic fg_q, fg_d;
	logic [3:0] acc_q, acc_d, edges_q, edges_d, inc;
	// One bit wider than the accumulator, so the sum of two terms never wraps early.
	logic [4:0] acc_sum;
	pulse_mode_type pmode;
	assign pmode = pulse_mode_type'(pin1_q.pulse_sel);

	always_comb begin
		fg_d = fg_q;
		acc_d = acc_q;
		edges_d = edges_q;
		case (pmode)
			PULSE_R24: inc = 4'd12;
			PULSE_R20: inc = 4'd10;
			PULSE_R08: inc = 4'd4;
			default: inc = 4'd0;
		endcase
		acc_sum = 5'(acc_q) + 5'(inc);
		case (pmode)
			PULSE_ONE: fg_d = pin1_q.hall[0];
			PULSE_THREE: if (hall_edge) fg_d = !fg_q;
			PULSE_R24, PULSE_R20, PULSE_R08: begin
				if (!pfast_d) begin
					fg_d = 1'b0;
					acc_d = 4'h0;
					edges_d = 4'h0;
				end else if (hall_edge) begin
					if (edges_q != 4'(`PULSE_START_EDGES)) begin
						edges_d = edges_q + 4'h1;
					end else if (acc_sum >= 5'(`PULSE_ACC_MOD)) begin
						acc_d = 4'(acc_sum - 5'(`PULSE_ACC_MOD));
						fg_d = !fg_q;
					end else begin
						acc_d = 4'(acc_sum);
					end
				end
			end
			default: fg_d = pin1_q.hall[0];
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fg_q <= 1'b0;
			acc_q <= 4'h0;
			edges_q <= 4'h0;
		end else begin
			fg_q <= fg_d;
			acc_q <= acc_d;
			edges_q <= edges_d;
		end
	end

	assign rotation_pulse_out = fg_q;

endmodule // bldc_sine_pwm_commutator

// >>> testbench/power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model (
	// Clock.
	input wire logic sys_clk,
	// Gate drive from the controller, bit 0 is phase U.
	input wire logic [2:0] high_gate,
	input wire logic [2:0] low_gate,
	// Phase node levels and shoot-through count.
	output logic [2:0] phase_level,
	output logic [15:0] shoot_cnt
);
	initial begin
		phase_level = 3'h0;
		shoot_cnt = 16'h0000;
	end

	// A node with neither switch on floats, so it shows a changing level, never a held one.
	always @(posedge sys_clk) begin
		if (|(high_gate & low_gate)) shoot_cnt <= shoot_cnt + 16'h0001;
		for (int i = 0; i < 3; i++) begin
			phase_level[i] <= high_gate[i] ? 1'b1 : (low_gate[i] ? 1'b0 : ~phase_level[i]);
		end
	end
endmodule // power_stage_model

// >>> testbench/bldc_commutator_asserts.sv
`timescale 1ns/1ps
module bldc_commutator_asserts import bldc_pkg::*; #(
	parameter int unsigned REF_DIV = 2,
	parameter int unsigned SLOW_TICKS = 200
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Inputs watched.
	input wire logic u_hall_plus,
	input wire logic v_hall_plus,
	input wire logic w_hall_plus,
	input wire logic [2:0] pulse_count_select,
	input wire logic [7:0] duty_command,
	// Outputs watched.
	input wire logic u_high_gate,
	input wire logic u_low_gate,
	input wire logic v_high_gate,
	input wire logic v_low_gate,
	input wire logic w_high_gate,
	input wire logic w_low_gate,
	input wire logic rotation_pulse_out,
	input wire logic sine_mode
);
	// The first reference tick may land one cycle after turn-off, hence 17 full ticks.
	localparam int DEAD_MIN = 17 * REF_DIV;
	localparam int SLOW_CYC = (SLOW_TICKS + 4) * REF_DIV + 8;
	logic [11:0] gap_q, gap_d;
	logic last_hi_q, last_hi_d;
	logic [31:0] quiet_q, quiet_d;
	logic [2:0] hall_q;
	logic gates_off;

	////////////////////////////////////////////////////////////////////////////////
	// Off time of phase U, last side on, and cycles since a Hall pin last moved.
	assign gates_off = ~|{u_high_gate, u_low_gate, v_high_gate, v_low_gate, w_high_gate, w_low_gate};
	always_comb begin
		gap_d = (u_high_gate || u_low_gate) ? 12'h000 : (gap_q == 12'hFFF ? gap_q : gap_q + 12'h001);
		last_hi_d = u_high_gate ? 1'b1 : (u_low_gate ? 1'b0 : last_hi_q);
		quiet_d = ({w_hall_plus, v_hall_plus, u_hall_plus} != hall_q) ? 32'h0 : quiet_q + 32'h1;
	end

	// Registers only; a long off time after reset counts as a full gap.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gap_q <= 12'hFFF;
			last_hi_q <= 1'b0;
			quiet_q <= 32'h0;
		end else begin
			gap_q <= gap_d;
			last_hi_q <= last_hi_d;
			quiet_q <= quiet_d;
		end
		hall_q <= {w_hall_plus, v_hall_plus, u_hall_plus};
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_u_exclusive: assert property (!(u_high_gate && u_low_gate))
		else $error("phase u gates on together");
	chk_v_exclusive: assert property (!(v_high_gate && v_low_gate))
		else $error("phase v gates on together");
	chk_w_exclusive: assert property (!(w_high_gate && w_low_gate))
		else $error("phase w gates on together");
	chk_dead_gap: assert property (($rose(u_low_gate) && last_hi_q)
		|| ($rose(u_high_gate) && !last_hi_q) |-> gap_q >= DEAD_MIN)
		else $error("phase u side change without full off time");
	chk_reset_quiet: assert property (disable iff (1'b0) rst |=> gates_off && !sine_mode
		&& !rotation_pulse_out) else $error("outputs active after reset");
	chk_duty_zero: assert property ((duty_command == 8'h00)[*8] |-> gates_off)
		else $error("gates on with zero duty");
	chk_one_copy: assert property ($changed(u_hall_plus) && pulse_count_select == 3'h0
		|-> ##[2:5] (rotation_pulse_out == u_hall_plus)) else $error("pulse not following u");
	chk_three_toggle: assert property ($changed({w_hall_plus, v_hall_plus, u_hall_plus})
		&& pulse_count_select == 3'h1 |-> ##[2:5] $changed(rotation_pulse_out))
		else $error("pulse missed a hall edge");
	chk_sine_edge: assert property ($rose(sine_mode) |-> quiet_q <= 8)
		else $error("sine drive started away from a hall edge");
	chk_slow_square: assert property (quiet_q > SLOW_CYC |-> !sine_mode)
		else $error("sine drive held past the slow limit");

	cover property ($rose(sine_mode));
	cover property ($rose(rotation_pulse_out) && pulse_count_select == 3'h2);
	cover property ($fell(u_high_gate) ##[1:100] $rose(u_low_gate));
endmodule // bldc_commutator_asserts

bind bldc_sine_pwm_commutator bldc_commutator_asserts #(.REF_DIV(REF_DIV), .SLOW_TICKS(SLOW_TICKS))
	u_chk (.sys_clk(sys_clk), .rst(rst), .u_hall_plus(u_hall_plus), .v_hall_plus(v_hall_plus),
	.w_hall_plus(w_hall_plus), .pulse_count_select(pulse_count_select),
	.duty_command(duty_command), .u_high_gate(u_high_gate), .u_low_gate(u_low_gate),
	.v_high_gate(v_high_gate), .v_low_gate(v_low_gate), .w_high_gate(w_high_gate),
	.w_low_gate(w_low_gate), .rotation_pulse_out(rotation_pulse_out), .sine_mode(sine_mode));

// >>> testbench/bldc_sine_pwm_commutator_bench.sv
`timescale 1ns/1ps
module bldc_sine_pwm_commutator_bench;
	localparam int RD = 2;
	logic sys_clk, rst, cap, sine_mode, rotation_pulse_out, pulse_prev;
	logic [2:0] hall, sel, hg, lg, phase_level;
	logic [4:0] adv;
	logic [7:0] duty;
	logic [15:0] shoot_cnt;
	int n_mismatch, checked, n_tog, idx;
	int pw[6] = '{0, 0, 1, 1, 2, 2};
	int lo[6] = '{1, 2, 2, 0, 0, 1};
	logic [2:0] fwd[6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};

	// Short counts keep the run small; expectations derive from the same values.
	bldc_sine_pwm_commutator #(.REF_DIV(RD), .SLOW_TICKS(200), .PULSE_SLOW_TICKS(300),
		.LOCK_ON_CYCLES(5), .LOCK_OFF_CYCLES(30)) u_dut (.sys_clk(sys_clk), .rst(rst),
		.u_hall_plus(hall[0]), .v_hall_plus(hall[1]), .w_hall_plus(hall[2]),
		.phase_advance_command(adv), .pulse_count_select(sel), .duty_command(duty),
		.lock_timer_cap(cap), .u_high_gate(hg[0]), .u_low_gate(lg[0]), .v_high_gate(hg[1]),
		.v_low_gate(lg[1]), .w_high_gate(hg[2]), .w_low_gate(lg[2]),
		.rotation_pulse_out(rotation_pulse_out), .sine_mode(sine_mode));
	power_stage_model u_stage (.sys_clk(sys_clk), .high_gate(hg), .low_gate(lg),
		.phase_level(phase_level), .shoot_cnt(shoot_cnt));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, and a pulse change counter sampled away from the launching edge.
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) begin
		if (rotation_pulse_out !== pulse_prev) n_tog++;
		pulse_prev = rotation_pulse_out;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic step(input logic [2:0] code, input int n);
		hall = code;
		idle(n);
	endtask

	task automatic hold_cnt(input int p, input logic v, inout int c);
		while (hg[p] === v && c < 3000) begin
			@(negedge sys_clk);
			c++;
		end
	endtask

	task automatic cap_edges(input int n);
		repeat (n) begin
			cap = 1'b1;
			idle(20);
			cap = 1'b0;
			idle(20);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Slow sectors at full duty: pattern, duty cap and carrier period per sector.
	task automatic t_square();
		int h, c, p, o, d;
		duty = 8'hFF;
		for (int k = 0; k < 6; k++) begin
			p = pw[k];
			o = 3 - p - lo[k];
			step(fwd[k], 1500);
			check(sine_mode, 1'b0);
			check({hg[o], lg[o], lg[lo[k]], phase_level[lo[k]]}, 4'h2);
			h = 0;
			repeat (1024) begin
				@(negedge sys_clk);
				h += hg[p];
			end
			check(h >= 800 && h <= 870, 1'b1);
			c = 0;
			hold_cnt(p, 1'b1, c);
			hold_cnt(p, 1'b0, c);
			c = 0;
			hold_cnt(p, 1'b1, c);
			hold_cnt(p, 1'b0, c);
			check(c, 512 * RD);
			// Off time from the high side falling to the low side rising.
			hold_cnt(p, 1'b1, c);
			d = 0;
			while (lg[p] === 1'b0 && d < 100) begin
				@(negedge sys_clk);
				d++;
			end
			check(d, 18 * RD);
		end
	endtask

	// Illegal Hall code and zero duty both turn every gate off.
	task automatic t_refuse();
		step(3'h7, 30);
		check({hg, lg}, 6'h00);
		step(3'h5, 1500);
		duty = 8'h00;
		idle(30);
		check({hg, lg}, 6'h00);
		duty = 8'hFF;
	endtask

	// Intervals just under and just over the limit of 200 reference ticks.
	task automatic t_speed();
		adv = 5'h10;
		for (int i = 0; i < 6; i++) step(fwd[i], 380);
		check(sine_mode, 1'b1);
		for (int i = 0; i < 2; i++) step(fwd[i], 440);
		check(sine_mode, 1'b0);
	endtask

	// Fast reverse rotation must never enter sine drive.
	task automatic t_reverse();
		for (int i = 0; i < 8; i++) begin
			step(fwd[(12 - i) % 6], 200);
			if (i > 0) check(sine_mode, 1'b0);
		end
	endtask

	// Every pulse setting: silent start for the three ratio settings, then changes over five electrical cycles.
	task automatic t_pulse();
		int t0, t1;
		int exp_tog[5] = '{10, 30, 24, 20, 8};
		for (int k = 0; k < 5; k++) begin
			sel = k[2:0];
			idle(800);
			if (k > 1) check(rotation_pulse_out, 1'b0);
			t0 = n_tog;
			// Nine edges after the slow one make 1.5 cycles; then count five full cycles.
			for (int i = 0; i < 40; i++) begin
				step(fwd[idx], 200);
				idx = (idx + 1) % 6;
				if (i == 9 && k > 1) check(n_tog - t0, 0);
				if (i == 9) t1 = n_tog;
			end
			check(n_tog - t1, exp_tog[k]);
		end
	endtask

	// A stalled rotor: five lock oscillator edges stop drive, thirty more restore it.
	task automatic t_lock();
		idle(1500);
		cap_edges(4);
		check(|{hg, lg}, 1'b1);
		cap_edges(3);
		check({hg, lg}, 6'h00);
		cap_edges(26);
		check({hg, lg}, 6'h00);
		cap_edges(5);
		idle(300);
		check(|{hg, lg}, 1'b1);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence; the watchdog covers a hung wait in any scenario.
	initial begin
		rst = 1'b1;
		hall = 3'h1;
		adv = 5'h00;
		sel = 3'h0;
		duty = 8'h80;
		cap = 1'b0;
		pulse_prev = 1'b0;
		idx = 0;
		idle(2);
		check({hg, lg, rotation_pulse_out, sine_mode}, 8'h00);
		rst = 1'b0;
		t_square();
		t_refuse();
		t_speed();
		t_reverse();
		t_pulse();
		t_lock();
		check(shoot_cnt, 16'h0000);
		results();
	end
	initial begin
		repeat (97000) @(posedge sys_clk);
		n_mismatch++;
		results();
	end
endmodule // bldc_sine_pwm_commutator_bench
